// ---- rtl/fss_defs.vh ----
// constants of the flash suspend and factory programming sequencer
`ifndef FSS_DEFS_VH
`define FSS_DEFS_VH
// register byte offsets
`define FSS_OFF_CMD 12'h000
`define FSS_OFF_DATA 12'h004
`define FSS_OFF_STAT 12'h008
`define FSS_OFF_CTRL 12'h00c
`define FSS_OFF_FADDR 12'h010
`define FSS_OFF_ARRAY 12'h014
// command codes
`define FSS_CMD_SUSPEND 8'hb0
`define FSS_CMD_RESUME 8'hd0
`define FSS_CMD_READ_ARRAY 8'hff
`define FSS_CMD_READ_STATUS 8'h70
`define FSS_CMD_BFP_SETUP 8'h80
`define FSS_CMD_BFP_CONFIRM 8'hd0
`define FSS_BFP_EXIT_DATA 16'hffff
// status bit positions
`define FSS_SR_READY 7
`define FSS_SR_ERS_SUSP 6
`define FSS_SR_VPEN_ERR 3
`define FSS_SR_PRG_SUSP 2
`define FSS_SR_LOCK_ERR 1
`define FSS_SR_BUF_BUSY 0
// control register fields
`define FSS_CTRL_PRG_START 0
`define FSS_CTRL_ERS_START 1
`define FSS_CTRL_VPEN_OK 2
`define FSS_CTRL_LOCKED 3
// buffer and timing
`define FSS_BUF_WORDS 32
`define FSS_OP_TIME_NS 1000
`define FSS_CLK_NS 25
`define FSS_OP_CYCLES (`FSS_OP_TIME_NS / `FSS_CLK_NS)
`define FSS_SUSP_CYCLES 16'h0004
`define FSS_WORD_CYCLES 16'h0002
`endif

// ---- rtl/fss_status_latch.v ----
// status snapshot that refreshes only at the start of a read cycle
module fss_status_latch (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // live status and read-cycle start
    input wire [7:0] live,
    input wire read_start,
    // held value
    output reg [7:0] held_q
);
    // a poll that does not start a new read keeps showing the old value
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_q <= 8'h80;
        end else if (read_start) begin
            held_q <= live;
        end
    end
endmodule

// ---- rtl/fss_seq.v ----
// flash suspend/resume and buffered factory programming sequencer
`include "fss_defs.vh"

module fss_seq #(
    parameter BUF_WORDS = `FSS_BUF_WORDS,
    parameter OP_CYCLES = `FSS_OP_CYCLES
) (
    // ahb-lite slave
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // array write port
    output reg arr_we,
    output reg [23:0] arr_addr,
    output reg [15:0] arr_wdata
);
    // ********************************************************
    // state codes
    // ********************************************************
    localparam ST_IDLE = 4'h0;
    localparam ST_PRG = 4'h1;
    localparam ST_PRG_SUSP = 4'h2;
    localparam ST_ERS = 4'h3;
    localparam ST_ERS_SUSP = 4'h4;
    localparam ST_BFP_SETUP = 4'h5;
    localparam ST_BFP_LOAD = 4'h6;
    localparam ST_BFP_PROG = 4'h7;
    localparam ST_BFP_EXIT = 4'h8;
    localparam ST_BFP_ARMED = 4'h9;

    // ********************************************************
    // registers
    // ********************************************************
    reg [3:0] st_q;
    reg [15:0] cnt_q;
    reg [5:0] wcnt_q;
    reg [4:0] pidx_q;
    reg [23:0] wa_q;
    reg [23:0] blk_q;
    reg [23:0] req_addr_q;
    reg [3:0] ctrl_q;
    reg status_mode_q;
    reg prg_susp_q;
    reg ers_susp_q;
    reg vpen_err_q;
    reg lock_err_q;
    reg refused_q;
    reg [15:0] buf_q [0:BUF_WORDS-1];
    reg dph_q;
    reg dwr_q;
    reg [11:0] daddr_q;
    wire [7:0] held;
    reg [7:0] live;
    integer i;

    function [7:0] cmd_of;
        input [31:0] w;
        begin
            cmd_of = w[7:0];
        end
    endfunction

    // block address is the word address above the 64k-word offset
    function same_block;
        input [23:0] a;
        input [23:0] b;
        begin
            same_block = (a[23:16] == b[23:16]);
        end
    endfunction

    wire busy = (st_q == ST_PRG) || (st_q == ST_ERS) || (st_q == ST_BFP_SETUP) ||
                (st_q == ST_BFP_PROG) || (st_q == ST_BFP_EXIT);
    wire in_bfp = (st_q == ST_BFP_LOAD) || (st_q == ST_BFP_PROG) || (st_q == ST_BFP_SETUP);

    always @* begin
        live = 8'h00;
        live[`FSS_SR_READY] = in_bfp ? 1'b0 : ~busy;
        live[`FSS_SR_ERS_SUSP] = ers_susp_q;
        live[`FSS_SR_PRG_SUSP] = prg_susp_q;
        live[`FSS_SR_VPEN_ERR] = vpen_err_q;
        live[`FSS_SR_LOCK_ERR] = lock_err_q;
        live[`FSS_SR_BUF_BUSY] = (st_q == ST_BFP_PROG);
        if ((st_q == ST_BFP_SETUP || st_q == ST_IDLE) && (vpen_err_q || lock_err_q)) begin
            live[`FSS_SR_READY] = 1'b1;
        end
    end

    wire dstat = dph_q && !dwr_q && (daddr_q == `FSS_OFF_STAT);
    wire aph = hsel && htrans[1] && hready;

    // snapshot taken when a status read is addressed, so one poll sees one consistent value
    fss_status_latch u_lat (
        .hclk(hclk),
        .hresetn(hresetn),
        .live(live),
        .read_start(aph && !hwrite && (haddr == `FSS_OFF_STAT)),
        .held_q(held)
    );

    wire dwrite = dph_q && dwr_q && hreadyout;

    // ********************************************************
    // bus slave: status reads take two cycles to give the latch its edge
    // ********************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q <= 1'b0;
            dwr_q <= 1'b0;
            daddr_q <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            if (aph) begin
                dph_q <= 1'b1;
                dwr_q <= hwrite;
                daddr_q <= haddr;
                hreadyout <= hwrite || (haddr != `FSS_OFF_STAT);
                // read data stands until the next read; writes leave it alone
                if (!hwrite) begin
                    case (haddr)
                        `FSS_OFF_CTRL: hrdata <= {28'h0000000, ctrl_q};
                        `FSS_OFF_FADDR: hrdata <= {8'h00, req_addr_q};
                        `FSS_OFF_ARRAY: hrdata <= {30'h00000000, status_mode_q, refused_q};
                        default: hrdata <= 32'h00000000;
                    endcase
                end
            end else if (dstat && !hreadyout) begin
                hreadyout <= 1'b1;
                hrdata <= {24'h000000, held};
            end else begin
                if (hreadyout) begin
                    dph_q <= 1'b0;
                end
            end
        end
    end

    // ********************************************************
    // write state machine
    // ********************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            wcnt_q <= 6'h00;
            pidx_q <= 5'h00;
            wa_q <= 24'h000000;
            blk_q <= 24'h000000;
            req_addr_q <= 24'h000000;
            ctrl_q <= 4'h4;
            status_mode_q <= 1'b0;
            prg_susp_q <= 1'b0;
            ers_susp_q <= 1'b0;
            vpen_err_q <= 1'b0;
            lock_err_q <= 1'b0;
            refused_q <= 1'b0;
            arr_we <= 1'b0;
            arr_addr <= 24'h000000;
            arr_wdata <= 16'h0000;
            for (i = 0; i < BUF_WORDS; i = i + 1) begin
                buf_q[i] <= 16'h0000;
            end
        end else begin
            arr_we <= 1'b0;
            // a suspended operation keeps its remaining time for the resume
            if (cnt_q != 16'h0000 && st_q != ST_PRG_SUSP && st_q != ST_ERS_SUSP) begin
                cnt_q <= cnt_q - 16'h0001;
            end
            if (dwrite && daddr_q == `FSS_OFF_FADDR) begin
                req_addr_q <= hwdata[23:0];
            end
            if (dwrite && daddr_q == `FSS_OFF_CTRL) begin
                ctrl_q <= hwdata[3:0];
            end
            if (dwrite && daddr_q == `FSS_OFF_CMD && cmd_of(hwdata) == `FSS_CMD_READ_ARRAY &&
                st_q != ST_BFP_LOAD) begin
                status_mode_q <= 1'b0;
            end
            if (dwrite && daddr_q == `FSS_OFF_CMD && cmd_of(hwdata) == `FSS_CMD_READ_STATUS) begin
                status_mode_q <= 1'b1;
            end
            if (dwrite && daddr_q == `FSS_OFF_ARRAY) begin
                // array access during an erase suspension must avoid that block
                refused_q <= (st_q == ST_ERS_SUSP) && same_block(req_addr_q, blk_q);
            end
            case (st_q)
                ST_IDLE: begin
                    if (dwrite && daddr_q == `FSS_OFF_CTRL && hwdata[`FSS_CTRL_PRG_START]) begin
                        st_q <= ST_PRG;
                        prg_susp_q <= 1'b0;
                        blk_q <= req_addr_q;
                        cnt_q <= OP_CYCLES[15:0];
                    end else if (dwrite && daddr_q == `FSS_OFF_CTRL && hwdata[`FSS_CTRL_ERS_START]) begin
                        st_q <= ST_ERS;
                        ers_susp_q <= 1'b0;
                        blk_q <= req_addr_q;
                        cnt_q <= OP_CYCLES[15:0];
                    end else if (dwrite && daddr_q == `FSS_OFF_CMD &&
                                 cmd_of(hwdata) == `FSS_CMD_BFP_SETUP) begin
                        st_q <= ST_BFP_ARMED;
                        wa_q <= req_addr_q;
                    end
                end
                ST_BFP_ARMED: begin
                    if (dwrite && daddr_q == `FSS_OFF_CMD) begin
                        if (cmd_of(hwdata) == `FSS_CMD_BFP_CONFIRM) begin
                            st_q <= ST_BFP_SETUP;
                            status_mode_q <= 1'b1;
                            vpen_err_q <= ~ctrl_q[`FSS_CTRL_VPEN_OK];
                            lock_err_q <= ctrl_q[`FSS_CTRL_LOCKED];
                            cnt_q <= `FSS_SUSP_CYCLES;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_BFP_SETUP: begin
                    if (vpen_err_q || lock_err_q) begin
                        st_q <= ST_IDLE;
                    end else if (cnt_q == 16'h0000) begin
                        st_q <= ST_BFP_LOAD;
                        wcnt_q <= 6'h00;
                    end
                end
                ST_BFP_LOAD: begin
                    if (dwrite && daddr_q == `FSS_OFF_DATA) begin
                        if (wcnt_q == 6'h00 && hwdata[15:0] == `FSS_BFP_EXIT_DATA) begin
                            st_q <= ST_BFP_EXIT;
                            cnt_q <= `FSS_SUSP_CYCLES;
                        end else begin
                            buf_q[wcnt_q[4:0]] <= hwdata[15:0];
                            if (wcnt_q == BUF_WORDS - 1) begin
                                st_q <= ST_BFP_PROG;
                                pidx_q <= 5'h00;
                                cnt_q <= `FSS_WORD_CYCLES;
                            end
                            wcnt_q <= wcnt_q + 6'h01;
                        end
                    end
                end
                ST_BFP_PROG: begin
                    if (cnt_q == 16'h0000) begin
                        arr_we <= 1'b1;
                        arr_addr <= wa_q;
                        arr_wdata <= buf_q[pidx_q];
                        wa_q <= wa_q + 24'h000001;
                        pidx_q <= pidx_q + 5'h01;
                        cnt_q <= `FSS_WORD_CYCLES;
                        if (pidx_q == BUF_WORDS - 1) begin
                            st_q <= ST_BFP_LOAD;
                            wcnt_q <= 6'h00;
                        end
                    end
                end
                ST_BFP_EXIT: begin
                    if (cnt_q == 16'h0000) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_PRG, ST_ERS: begin
                    if (dwrite && daddr_q == `FSS_OFF_CMD && cmd_of(hwdata) == `FSS_CMD_SUSPEND &&
                        cnt_q > `FSS_SUSP_CYCLES) begin
                        st_q <= (st_q == ST_PRG) ? ST_PRG_SUSP : ST_ERS_SUSP;
                        prg_susp_q <= (st_q == ST_PRG);
                        ers_susp_q <= (st_q == ST_ERS);
                        status_mode_q <= 1'b1;
                    end else if (cnt_q == 16'h0000) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_PRG_SUSP, ST_ERS_SUSP: begin
                    // resume only matters here; other states ignore it, except ST_BFP_ARMED where the same code is the confirm
                    if (dwrite && daddr_q == `FSS_OFF_CMD && cmd_of(hwdata) == `FSS_CMD_RESUME &&
                        (st_q == ST_PRG_SUSP || same_block(req_addr_q, blk_q))) begin
                        st_q <= (st_q == ST_PRG_SUSP) ? ST_PRG : ST_ERS;
                        prg_susp_q <= 1'b0;
                        ers_susp_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- testbench/fss_seq_checker.sv ----
// port assertions for the flash suspend and factory programming sequencer
module fss_seq_checker #(
    parameter BUF_WORDS = 32,
    parameter OP_CYCLES = 40
) (
    // bus side
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // array side
    input wire arr_we,
    input wire [23:0] arr_addr,
    input wire [15:0] arr_wdata
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire acc = hsel && htrans[1] && hready;
    wire rd_acc = acc && !hwrite;
    wire rd_stat = rd_acc && haddr == 12'h008;
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
    a_status_wait: assert property (rd_stat |=> !hreadyout ##1 hreadyout) else $error("status wait wrong");
    a_plain_nowait: assert property (acc && !rd_stat |=> hreadyout) else $error("unexpected wait state");
    a_we_pulse: assert property (arr_we |=> !arr_we) else $error("array write not a pulse");
    a_reset_idle: assert property ($rose(hresetn) |-> hreadyout && !arr_we && hrdata == 32'h0)
        else $error("outputs not idle after reset");
    a_rdata_hold: assert property (!$stable(hrdata) |-> $past(rd_acc) || $past(rd_acc, 2))
        else $error("read data changed without a read");
    a_stat_fields: assert property (rd_stat |-> ##2 hrdata[5:4] == 2'b00) else $error("unused status bits set");
    a_susp_ready: assert property (rd_stat ##2 (hrdata[6] || hrdata[2]) |-> hrdata[7])
        else $error("suspended while busy");
    c_prog_susp: cover property (rd_stat ##2 hrdata[2]);
    c_erase_susp: cover property (rd_stat ##2 hrdata[6]);
    c_buf_busy: cover property (rd_stat ##2 hrdata[0]);
    c_arr_write: cover property (arr_we);
endmodule

// ---- testbench/fss_host.sv ----
// host controller model: single-word bus master for commands and polls
module fss_host (
    // clock and bus answer
    input wire hclk,
    input wire hready,
    input wire [31:0] hrdata,
    // bus request
    output logic hsel,
    output logic [11:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end
    // every poll is its own transfer, so the status snapshot is refreshed each time
    task automatic xfer(input [11:0] a, input w, input [31:0] d, output [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : ~hwdata;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        r = hrdata;
        // released data lines flip so a stale value is never mistaken for a fresh one
        hwdata <= ~hwdata;
    endtask
endmodule

// ---- testbench/fss_seq_test.sv ----
// self-checking bench for the flash sequencer
module fss_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn;
    wire hsel, hwrite, hreadyout, hresp, arr_we;
    wire [11:0] haddr;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [31:0] hwdata, hrdata;
    wire [23:0] arr_addr;
    wire [15:0] arr_wdata;
    wire hready = hreadyout;
    int error_cnt = 0;
    int total_checks = 0;
    logic [23:0] qa[$];
    logic [15:0] qd[$], dq[$];
    logic [31:0] r, w;
    logic [7:0] s;
    logic [23:0] fa;
    fss_host host_i (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    fss_seq #(.BUF_WORDS(32), .OP_CYCLES(40)) fss_seq_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .arr_we, .arr_addr, .arr_wdata);
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) if (arr_we) begin
        qa.push_back(arr_addr);
        qd.push_back(arr_wdata);
    end
    task chk_stat(input [7:0] got, input [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t status %h expected %h", $time, got, exp);
        end
    endtask
    task chk_arr(input [39:0] got, input [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t array write %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        host_i.xfer(a, 1'b1, d, r);
    endtask
    task automatic poll(input [7:0] mask, input [7:0] val);
        int n = 0;
        do begin
            host_i.xfer(12'h008, 1'b0, 32'h0, r);
            n++;
        end while ((r[7:0] & mask) != val && n < 300);
        s = r[7:0];
        if (n >= 300) begin
            error_cnt++;
            $display("MISMATCH %0t status poll timed out", $time);
        end
    endtask
    // status after a suspend request: ready plus the bit of the operation still pending
    function [7:0] exp_susp(input erase, input late);
        exp_susp = late ? 8'h80 : (erase ? 8'hc0 : 8'h84);
    endfunction
    task final_report;
        if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #(25 * 30000);
        error_cnt++;
        $display("MISMATCH %0t run did not finish", $time);
        final_report;
    end
    initial begin
        hresetn = 1'b0;
        void'($urandom(63479));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        poll(8'hff, 8'h80);
        chk_stat(s, 8'h80);
        host_i.xfer(12'h0f0, 1'b0, 32'h0, r);
        chk_stat(r[7:0], 8'h00);
        wr(12'h000, 32'hb0);
        wr(12'h000, 32'hd0);
        poll(8'hff, 8'h80);
        chk_stat(s, 8'h80);
        for (int k = 0; k < 4; k++) begin
            fa = $urandom;
            wr(12'h010, {8'h0, fa});
            wr(12'h00c, k[0] ? 32'h6 : 32'h5);
            if (k[1]) repeat (45) @(posedge hclk);
            wr(12'h000, 32'hb0);
            if (k[0]) wr(12'h000, 32'h70);
            poll(8'h80, 8'h80);
            chk_stat(s, exp_susp(k[0], k[1]));
            if (k == 0) begin
                wr(12'h000, 32'hff);
                wr(12'h010, {8'h0, fa ^ 24'h010000});
                wr(12'h014, 32'h5678);
                host_i.xfer(12'h014, 1'b0, 32'h0, r);
                chk_stat({6'h0, r[1:0]}, 8'h00);
                wr(12'h010, {8'h0, fa});
            end
            if (k == 1) begin
                wr(12'h014, 32'h1234);
                host_i.xfer(12'h014, 1'b0, 32'h0, r);
                chk_stat({6'h0, r[1:0]}, 8'h03);
                wr(12'h010, {8'h0, fa ^ 24'h010000});
                wr(12'h014, 32'h1234);
                host_i.xfer(12'h014, 1'b0, 32'h0, r);
                chk_stat({6'h0, r[1:0]}, 8'h02);
                wr(12'h000, 32'hd0);
                host_i.xfer(12'h008, 1'b0, 32'h0, r);
                chk_stat(r[7:0], 8'hc0);
                wr(12'h010, {8'h0, fa});
            end
            if (!k[1]) begin
                wr(12'h000, 32'hd0);
                poll(8'hc4, 8'h80);
                chk_stat(s, 8'h80);
            end
            wr(12'h000, 32'hff);
            host_i.xfer(12'h014, 1'b0, 32'h0, r);
            chk_stat({7'h0, r[1]}, 8'h00);
        end
        fa = $urandom & 32'h00ffffe0;
        wr(12'h00c, 32'h4);
        wr(12'h010, {8'h0, fa});
        wr(12'h000, 32'h80);
        wr(12'h000, 32'hd0);
        poll(8'h80, 8'h00);
        chk_stat(s & 8'h8a, 8'h00);
        qa.delete();
        qd.delete();
        for (int b = 0; b < 2; b++) begin
            poll(8'h01, 8'h00);
            for (int i = 0; i < 32; i++) begin
                w = $urandom;
                if (w[15:0] == 16'hffff) w[0] = 1'b0;
                dq.push_back(w[15:0]);
                wr(12'h004, w);
            end
            host_i.xfer(12'h008, 1'b0, 32'h0, r);
            chk_stat({7'h0, r[0]}, 8'h01);
            poll(8'h01, 8'h00);
            chk_stat({7'h0, s[0]}, 8'h00);
        end
        wr(12'h004, 32'hffff);
        poll(8'h80, 8'h80);
        chk_stat(s, 8'h80);
        chk_arr({8'h0, qa.size()}, 40'd64);
        for (int i = 0; i < 64 && i < qa.size(); i++) chk_arr({qa[i], qd[i]}, {fa + i[23:0], dq[i]});
        wr(12'h00c, 32'h8);
        wr(12'h000, 32'h80);
        wr(12'h000, 32'hd0);
        poll(8'h8a, 8'h8a);
        chk_stat(s, 8'h8a);
        wr(12'h000, 32'hff);
        final_report;
    end
endmodule
bind fss_seq fss_seq_checker #(.BUF_WORDS(BUF_WORDS), .OP_CYCLES(OP_CYCLES)) chk_i (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .arr_we, .arr_addr, .arr_wdata);
